// *** pkg/nsl_pkg.sv ***
package nsl_pkg;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] CFG_OFS  = 8'h00;
  localparam logic [7:0] PROT_OFS = 8'h04;
  localparam logic [7:0] DIV_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;

  // ==========================================================
  // Configuration register fields
  localparam int CFG_DBG_BIT    = 7;
  localparam int CFG_SHWDIS_BIT = 6;
  localparam int CFG_LOAD_LSB   = 4;
  localparam int CFG_FIXED_BIT  = 3;
  localparam int CFG_RW_MSB     = 2;
  localparam logic [7:0] CFG_RST = 8'h0c;

  // ==========================================================
  // Protection, divider and status fields
  localparam int PROT_SHW_BIT = 7;
  localparam logic PROT_RST   = 1'b1;
  localparam int DIV_W        = 10;
  localparam int DIVH_W       = 2;
  localparam logic [DIV_W-1:0] DIV_RST = 10'h000;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_SPEC_BIT = 2;

  // ==========================================================
  // Shadow word locations and erased value
  localparam logic [11:0] SHW_HI_ADDR = 12'hfc0;
  localparam logic [11:0] SHW_LO_ADDR = 12'hfc1;
  localparam logic [7:0]  SHW_ERASED  = 8'hff;

  // ==========================================================
  // Bus responses and loader states
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_LOAD_HI = 4'b0001,
    ST_LOAD_LO = 4'b0010,
    ST_APPLY   = 4'b0100,
    ST_RUN     = 4'b1000
  } nsl_state_t;

endpackage

// *** hw/nsl_shadow_store.sv ***
`timescale 1ns/1ps
module nsl_shadow_store
  import nsl_pkg::*;
#(
  parameter logic [15:0] INIT = 16'hffff
)(
  // Clock and control
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       ce_i,
  // Read port
  input  wire logic       rd_sel_i,
  output logic [7:0]      rd_data_o,
  // Program and erase port
  input  wire logic       wr_sel_i,
  input  wire logic       pgm_i,
  input  wire logic       ers_i,
  input  wire logic [7:0] wdata_i
);

  // ==========================================================
  // Nonvolatile cells, kept through reset
  logic [7:0] mem_ff [2] = '{INIT[15:8], INIT[7:0]};
  logic [7:0] rd_data_ff;

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_cell
      always_ff @(posedge clk_i)
      begin
        if (ce_i && (wr_sel_i == 1'(g)))
        begin
          if (ers_i)
            mem_ff[g] <= SHW_ERASED;
          else if (pgm_i)
            mem_ff[g] <= mem_ff[g] & wdata_i;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Registered read
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rd_data_ff <= 8'h00;
    else if (ce_i)
      rd_data_ff <= mem_ff[rd_sel_i];
  end

  assign rd_data_o = rd_data_ff;

endmodule // nsl_shadow_store

// *** hw/nsl_axil_slave.sv ***
`timescale 1ns/1ps
module nsl_axil_slave
  import nsl_pkg::*;
#(
  parameter int AW = 8
)(
  // Clock and control
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          ce_i,
  input  wire logic          en_i,
  // Write channels
  input  wire logic [AW-1:0] awaddr_i,
  input  wire logic          awvalid_i,
  output logic               awready_o,
  input  wire logic [31:0]   wdata_i,
  input  wire logic [3:0]    wstrb_i,
  input  wire logic          wvalid_i,
  output logic               wready_o,
  output logic [1:0]         bresp_o,
  output logic               bvalid_o,
  input  wire logic          bready_i,
  // Read channels
  input  wire logic [AW-1:0] araddr_i,
  input  wire logic          arvalid_i,
  output logic               arready_o,
  output logic [31:0]        rdata_o,
  output logic [1:0]         rresp_o,
  output logic               rvalid_o,
  input  wire logic          rready_i,
  // Core side
  output logic               wr_req_o,
  output logic [AW-1:0]      wr_addr_o,
  output logic [31:0]        wr_data_o,
  output logic [3:0]         wr_strb_o,
  input  wire logic          wr_err_i,
  output logic               rd_req_o,
  output logic [AW-1:0]      rd_addr_o,
  input  wire logic [31:0]   rd_data_i,
  input  wire logic          rd_err_i
);

  logic          aw_got_ff, w_got_ff, ar_got_ff;
  logic          awready_ff, wready_ff, arready_ff;
  logic          bvalid_ff, rvalid_ff;
  logic [1:0]    bresp_ff, rresp_ff;
  logic [AW-1:0] awaddr_ff, araddr_ff;
  logic [31:0]   wdata_ff, rdata_ff;
  logic [3:0]    wstrb_ff;
  logic          aw_hs, w_hs, ar_hs, wr_fire, rd_fire;

  assign aw_hs   = awvalid_i && awready_ff;
  assign w_hs    = wvalid_i && wready_ff;
  assign ar_hs   = arvalid_i && arready_ff;
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
  assign rd_fire = ar_got_ff && !rvalid_ff;

  // ==========================================================
  // Write address and data capture
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (aw_hs)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= awaddr_i;
      end
      else if (wr_fire)
        aw_got_ff <= 1'b0;
      if (w_hs)
      begin
        w_got_ff <= 1'b1;
        wdata_ff <= wdata_i;
        wstrb_ff <= wstrb_i;
      end
      else if (wr_fire)
        w_got_ff <= 1'b0;
      awready_ff <= en_i && !aw_got_ff && !aw_hs && !bvalid_ff;
      wready_ff  <= en_i && !w_got_ff && !w_hs && !bvalid_ff;
    end
  end

  // ==========================================================
  // Write response
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (wr_fire)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_err_i ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bvalid_ff && bready_i)
        bvalid_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Read address, data and response
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ar_got_ff  <= 1'b0;
      araddr_ff  <= '0;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (ar_hs)
      begin
        ar_got_ff <= 1'b1;
        araddr_ff <= araddr_i;
      end
      else if (rd_fire)
        ar_got_ff <= 1'b0;
      arready_ff <= en_i && !ar_got_ff && !ar_hs && !rvalid_ff;
      if (rd_fire)
      begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_data_i;
        rresp_ff  <= rd_err_i ? RESP_SLVERR : RESP_OKAY;
      end
      else if (rvalid_ff && rready_i)
        rvalid_ff <= 1'b0;
    end
  end

  assign awready_o = awready_ff;
  assign wready_o  = wready_ff;
  assign bvalid_o  = bvalid_ff;
  assign bresp_o   = bresp_ff;
  assign arready_o = arready_ff;
  assign rvalid_o  = rvalid_ff;
  assign rdata_o   = rdata_ff;
  assign rresp_o   = rresp_ff;
  assign wr_req_o  = wr_fire && ce_i;
  assign wr_addr_o = awaddr_ff;
  assign wr_data_o = wdata_ff;
  assign wr_strb_o = wstrb_ff;
  assign rd_req_o  = rd_fire && ce_i;
  assign rd_addr_o = araddr_ff;

endmodule // nsl_axil_slave

// *** hw/nsl_config_loader.sv ***
// Contract
// - Shadow word sits at top two locations
// - Reset loads shadow into config and divider
// - High nibble to config, bits 1:0 divider
// - Normal mode: divider accepts first write only
// - Top locations served from shadow when enabled
// - Protected shadow refuses program and erase
// - Zero divider blocks every program or erase
`timescale 1ns/1ps
module nsl_config_loader
  import nsl_pkg::*;
#(
  parameter int          AW       = 8,
  parameter logic [15:0] SHW_INIT = 16'hffff
)(
  // Clock, reset, mode
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             special_mode_n_i,
  // Register bus
  input  wire logic [AW-1:0]    s_axi_awaddr_i,
  input  wire logic             s_axi_awvalid_i,
  output logic                  s_axi_awready_o,
  input  wire logic [31:0]      s_axi_wdata_i,
  input  wire logic [3:0]       s_axi_wstrb_i,
  input  wire logic             s_axi_wvalid_i,
  output logic                  s_axi_wready_o,
  output logic [1:0]            s_axi_bresp_o,
  output logic                  s_axi_bvalid_o,
  input  wire logic             s_axi_bready_i,
  input  wire logic [AW-1:0]    s_axi_araddr_i,
  input  wire logic             s_axi_arvalid_i,
  output logic                  s_axi_arready_o,
  output logic [31:0]           s_axi_rdata_o,
  output logic [1:0]            s_axi_rresp_o,
  output logic                  s_axi_rvalid_o,
  input  wire logic             s_axi_rready_i,
  // Array read path
  input  wire logic             rd_req_i,
  input  wire logic [11:0]      rd_addr_i,
  output logic [7:0]            rd_data_o,
  output logic                  shadow_hit_o,
  // Program and erase path
  input  wire logic             pe_req_i,
  input  wire logic             pe_erase_i,
  input  wire logic [11:0]      pe_addr_i,
  input  wire logic [7:0]       pe_data_i,
  output logic                  pe_start_o,
  output logic                  pe_shadow_o,
  output logic                  pe_refused_o,
  // Configuration outputs
  output logic                  debug_lockout_disable_o,
  output logic                  shadow_disable_o,
  output logic [DIV_W-1:0]      prog_divider_o,
  output logic                  load_done_o
);

  nsl_state_t       state_ff;
  logic [7:0]       cfg_ff;
  logic             prot_ff;
  logic [DIV_W-1:0] div_ff;
  logic             div_seen_ff;
  logic [7:0]       shw_hi_ff;
  logic             load_done_ff;
  logic             hit_ff;
  logic             pe_start_ff, pe_shadow_ff, pe_refused_ff;
  logic             wr_req, rd_req, wr_err, rd_err;
  logic [AW-1:0]    wr_addr, rd_addr;
  logic [31:0]      wr_data, rd_data;
  logic [3:0]       wr_strb;
  logic [7:0]       store_q;
  logic             store_sel, pe_ok, pe_hit, pe_refuse;
  logic             shw_pgm, shw_ers, rd_hit, run;

  // ==========================================================
  // Bus slave, held off until the load is done
  nsl_axil_slave #(
    .AW (AW)
  ) u_slave (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .en_i      (load_done_ff),
    .awaddr_i  (s_axi_awaddr_i),
    .awvalid_i (s_axi_awvalid_i),
    .awready_o (s_axi_awready_o),
    .wdata_i   (s_axi_wdata_i),
    .wstrb_i   (s_axi_wstrb_i),
    .wvalid_i  (s_axi_wvalid_i),
    .wready_o  (s_axi_wready_o),
    .bresp_o   (s_axi_bresp_o),
    .bvalid_o  (s_axi_bvalid_o),
    .bready_i  (s_axi_bready_i),
    .araddr_i  (s_axi_araddr_i),
    .arvalid_i (s_axi_arvalid_i),
    .arready_o (s_axi_arready_o),
    .rdata_o   (s_axi_rdata_o),
    .rresp_o   (s_axi_rresp_o),
    .rvalid_o  (s_axi_rvalid_o),
    .rready_i  (s_axi_rready_i),
    .wr_req_o  (wr_req),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_strb_o (wr_strb),
    .wr_err_i  (wr_err),
    .rd_req_o  (rd_req),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_err_i  (rd_err)
  );

  // ==========================================================
  // Shadow word cells
  assign run = (state_ff == ST_RUN);
  assign store_sel = (state_ff == ST_LOAD_HI) ? 1'b0 :
                     (state_ff == ST_RUN) ? rd_addr_i[0] : 1'b1;

  nsl_shadow_store #(
    .INIT (SHW_INIT)
  ) u_store (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .rd_sel_i  (store_sel),
    .rd_data_o (store_q),
    .wr_sel_i  (pe_addr_i[0]),
    .pgm_i     (shw_pgm),
    .ers_i     (shw_ers),
    .wdata_i   (pe_data_i)
  );

  // ==========================================================
  // Load sequence after reset
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_ff     <= ST_LOAD_HI;
      shw_hi_ff    <= 8'h00;
      load_done_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      unique case (state_ff)
        ST_LOAD_HI: state_ff <= ST_LOAD_LO;
        ST_LOAD_LO:
        begin
          shw_hi_ff <= store_q;
          state_ff  <= ST_APPLY;
        end
        ST_APPLY:
        begin
          load_done_ff <= 1'b1;
          state_ff     <= ST_RUN;
        end
        ST_RUN: state_ff <= ST_RUN;
        default: state_ff <= ST_LOAD_HI;
      endcase
    end
  end

  // ==========================================================
  // Configuration register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cfg_ff <= CFG_RST;
    else if (ce_i)
    begin
      if (state_ff == ST_APPLY)
        cfg_ff[7:CFG_LOAD_LSB] <= shw_hi_ff[7:CFG_LOAD_LSB];
      else if (wr_req && wr_addr == CFG_OFS && wr_strb[0])
      begin
        cfg_ff[CFG_RW_MSB:0] <= wr_data[CFG_RW_MSB:0];
        if (!special_mode_n_i)
          cfg_ff[7:CFG_LOAD_LSB] <= wr_data[7:CFG_LOAD_LSB];
      end
    end
  end

  // ==========================================================
  // Shadow protection, locked by the config lock bit
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      prot_ff <= PROT_RST;
    else if (ce_i && wr_req && wr_addr == PROT_OFS && wr_strb[0]
             && !cfg_ff[1])
      prot_ff <= wr_data[PROT_SHW_BIT];
  end

  // ==========================================================
  // Divider, loaded at reset then write once in normal mode
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      div_ff      <= DIV_RST;
      div_seen_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (state_ff == ST_APPLY)
        div_ff <= {shw_hi_ff[DIVH_W-1:0], store_q};
      else if (wr_req && wr_addr == DIV_OFS)
      begin
        div_seen_ff <= 1'b1;
        if (!div_seen_ff || !special_mode_n_i)
        begin
          if (wr_strb[0])
            div_ff[7:0] <= wr_data[7:0];
          if (wr_strb[1])
            div_ff[DIV_W-1:8] <= wr_data[DIV_W-1:8];
        end
      end
    end
  end

  // ==========================================================
  // Register decode
  always_comb
  begin
    wr_err = !(wr_addr == CFG_OFS || wr_addr == PROT_OFS ||
               wr_addr == DIV_OFS || wr_addr == STAT_OFS);
    rd_err = 1'b0;
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      CFG_OFS:  rd_data[7:0] = cfg_ff | CFG_RST & 8'h08;
      PROT_OFS: rd_data[PROT_SHW_BIT] = prot_ff;
      DIV_OFS:  rd_data[DIV_W-1:0] = div_ff;
      STAT_OFS:
      begin
        rd_data[STAT_DONE_BIT] = load_done_ff;
        rd_data[STAT_LOCK_BIT] = div_seen_ff;
        rd_data[STAT_SPEC_BIT] = !special_mode_n_i;
      end
      default:  rd_err = 1'b1;
    endcase
  end

  // ==========================================================
  // Array read mapping
  assign rd_hit = !cfg_ff[CFG_SHWDIS_BIT] &&
                  (rd_addr_i == SHW_HI_ADDR || rd_addr_i == SHW_LO_ADDR);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      hit_ff <= 1'b0;
    else if (ce_i)
      hit_ff <= run && rd_req_i && rd_hit;
  end

  // ==========================================================
  // Program and erase steering
  assign pe_hit = !cfg_ff[CFG_SHWDIS_BIT] &&
                  (pe_addr_i == SHW_HI_ADDR || pe_addr_i == SHW_LO_ADDR);
  assign pe_ok = run && pe_req_i;
  assign pe_refuse = (div_ff == DIV_RST) || (pe_hit && prot_ff);
  assign shw_pgm = pe_ok && !pe_refuse && pe_hit && !pe_erase_i;
  assign shw_ers = pe_ok && !pe_refuse && pe_hit && pe_erase_i;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pe_start_ff   <= 1'b0;
      pe_shadow_ff  <= 1'b0;
      pe_refused_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      pe_start_ff   <= pe_ok && !pe_refuse && !pe_hit;
      pe_shadow_ff  <= pe_ok && !pe_refuse && pe_hit;
      pe_refused_ff <= pe_ok && pe_refuse;
    end
  end

  assign rd_data_o               = store_q;
  assign shadow_hit_o            = hit_ff;
  assign pe_start_o              = pe_start_ff;
  assign pe_shadow_o             = pe_shadow_ff;
  assign pe_refused_o            = pe_refused_ff;
  assign debug_lockout_disable_o = cfg_ff[CFG_DBG_BIT];
  assign shadow_disable_o        = cfg_ff[CFG_SHWDIS_BIT];
  assign prog_divider_o          = div_ff;
  assign load_done_o             = load_done_ff;

  // ==========================================================
  // Checks
  sequence s_top_req;
    pe_req_i && run && ce_i && !cfg_ff[CFG_SHWDIS_BIT] &&
    (pe_addr_i == SHW_HI_ADDR || pe_addr_i == SHW_LO_ADDR);
  endsequence

  a_shadow_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_req_i && run && ce_i && !cfg_ff[CFG_SHWDIS_BIT] &&
    rd_addr_i == SHW_LO_ADDR |=> shadow_hit_o)
    else $error("top location not mapped to shadow");

  a_load_config: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(load_done_ff) |-> cfg_ff[7:4] == shw_hi_ff[7:4])
    else $error("config not loaded from shadow");

  a_load_divider: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(load_done_ff) |-> prog_divider_o[9:8] == shw_hi_ff[1:0] &&
    prog_divider_o[7:0] == $past(store_q))
    else $error("divider not loaded from shadow");

  a_div_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_req && wr_addr == DIV_OFS && div_seen_ff && special_mode_n_i
    |=> $stable(prog_divider_o))
    else $error("divider rewritten in normal mode");

  a_top_serve: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_top_req ##0 (!prot_ff && div_ff != DIV_RST)
    |=> pe_shadow_o && !pe_start_o)
    else $error("top location not served by shadow");

  a_shadow_prot: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_top_req ##0 prot_ff |=> pe_refused_o && !pe_shadow_o)
    else $error("protected shadow changed");

  a_div_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pe_req_i && run && ce_i && div_ff == DIV_RST
    |=> pe_refused_o && !pe_start_o && !pe_shadow_o)
    else $error("cycle started with zero divider");

  a_load_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !load_done_ff |-> !s_axi_awready_o && !s_axi_arready_o &&
    !s_axi_wready_o)
    else $error("bus open before load");

  a_load_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (rst_n_i && !load_done_ff && ce_i)[*3] |=> load_done_ff)
    else $error("load took too long");

endmodule // nsl_config_loader

// *** bench/nsl_array_agent.sv ***
`timescale 1ns/1ps
// ==========================================
// Array side requester
module nsl_array_agent (
  input  wire logic clk_i,
  output logic        rd_req_o,
  output logic [11:0] rd_addr_o,
  output logic        pe_req_o,
  output logic        pe_erase_o,
  output logic [11:0] pe_addr_o,
  output logic [7:0]  pe_data_o
);
  initial
  begin
    rd_req_o   = 1'b0;
    rd_addr_o  = 12'h000;
    pe_req_o   = 1'b0;
    pe_erase_o = 1'b0;
    pe_addr_o  = 12'h000;
    pe_data_o  = 8'h00;
  end

  // One cycle read, released address inverted
  task automatic rd(input logic [11:0] a);
  begin
    @(posedge clk_i);
    rd_req_o  <= 1'b1;
    rd_addr_o <= a;
    @(posedge clk_i);
    rd_req_o  <= 1'b0;
    rd_addr_o <= ~a;
    #1;
  end
  endtask

  // One cycle program or erase request
  task automatic pe(input logic e, input logic [11:0] a, input logic [7:0] d);
  begin
    @(posedge clk_i);
    pe_req_o   <= 1'b1;
    pe_erase_o <= e;
    pe_addr_o  <= a;
    pe_data_o  <= d;
    @(posedge clk_i);
    pe_req_o   <= 1'b0;
    pe_erase_o <= ~e;
    pe_addr_o  <= ~a;
    pe_data_o  <= ~d;
    #1;
  end
  endtask
endmodule // nsl_array_agent

// *** bench/nsl_config_loader_tb.sv ***
`timescale 1ns/1ps
module nsl_config_loader_tb;
  import nsl_pkg::*;
  // ==========================================
  // Signals and model state
  logic        clk_i = 0;
  logic        rst_n_i = 0;
  logic        ce_i = 1;
  logic        special_mode_n_i = 1;
  logic [7:0]  s_axi_awaddr_i = 0;
  logic [7:0]  s_axi_araddr_i = 0;
  logic [31:0] s_axi_wdata_i = 0;
  logic [3:0]  s_axi_wstrb_i = 0;
  logic        s_axi_awvalid_i = 0;
  logic        s_axi_wvalid_i = 0;
  logic        s_axi_bready_i = 0;
  logic        s_axi_arvalid_i = 0;
  logic        s_axi_rready_i = 0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic        s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rs;
  logic [31:0] s_axi_rdata_o, d;
  logic        rd_req_i, pe_req_i, pe_erase_i, shadow_hit_o;
  logic        pe_start_o, pe_shadow_o, pe_refused_o, load_done_o;
  logic        debug_lockout_disable_o, shadow_disable_o;
  logic [7:0]  rd_data_o, pe_data_i;
  logic [11:0] rd_addr_i, pe_addr_i;
  logic [DIV_W-1:0] prog_divider_o;
  int          errors = 0;
  int          checks = 0;
  int          hi = 8'h3f;
  int          lo = 8'h23;
  int          dv;
  int          r;

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  nsl_config_loader #(.SHW_INIT(16'h3f23)) u_dut (.*);
  nsl_array_agent u_arr (
    .clk_i      (clk_i),
    .rd_req_o   (rd_req_i),
    .rd_addr_o  (rd_addr_i),
    .pe_req_o   (pe_req_i),
    .pe_erase_o (pe_erase_i),
    .pe_addr_o  (pe_addr_i),
    .pe_data_o  (pe_data_i)
  );

  // ==========================================
  // Tasks
  task automatic give_verdict;
  begin
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
  begin
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  end
  endtask

  task automatic rst;
  begin
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    ce_i    <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(load_done_o, 0);
    ce_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(load_done_o, 1);
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
  begin
    @(posedge clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= v;
    s_axi_wstrb_i   <= 4'hf;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end
    while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    rs = s_axi_bresp_o;
  end
  endtask

  task automatic rd(input logic [7:0] a);
  begin
    @(posedge clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end
    while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    d = s_axi_rdata_o;
    rs = s_axi_rresp_o;
  end
  endtask

  // Array read: negative expectation means no shadow hit
  task automatic ar(input logic [11:0] a, input int e);
  begin
    u_arr.rd(a);
    if (e < 0)
      chk(shadow_hit_o, 0);
    else
      chk({shadow_hit_o, rd_data_o}, e | 32'h100);
  end
  endtask

  task automatic pc(input logic er, input logic [11:0] a,
                    input logic [7:0] v, input logic [2:0] e);
  begin
    u_arr.pe(er, a, v);
    chk({pe_start_o, pe_shadow_o, pe_refused_o}, e);
  end
  endtask

  // ==========================================
  // Tests
  initial
  begin
    r = $urandom(32'ha40f);
    rst();
    for (int k = 0; k < 2; k++)
    begin
      dv = ((hi & 3) << 8) | lo;
      rd(CFG_OFS);
      chk(d, (hi & 8'hf0) | 8'h0c);
      rd(DIV_OFS);
      chk(d, dv);
      chk(rs, RESP_OKAY);
      chk(prog_divider_o, dv);
      chk({debug_lockout_disable_o, shadow_disable_o}, hi >> 6);
      if (k == 1)
        give_verdict();
      wr(CFG_OFS, 32'hfc);
      rd(CFG_OFS);
      chk(d, (hi & 8'hf0) | 8'h0c);
      r = $urandom_range(1023, 1);
      wr(DIV_OFS, r);
      wr(DIV_OFS, ~r);
      rd(DIV_OFS);
      chk(d, r);
      chk(prog_divider_o, r);
      wr(8'h20, 1);
      chk(rs, RESP_SLVERR);
      rd(8'h20);
      chk(rs, RESP_SLVERR);
      ar(SHW_HI_ADDR, hi);
      ar(SHW_LO_ADDR, lo);
      ar(12'hfbf, -1);
      pc(0, SHW_LO_ADDR, 8'h00, 3'b001);
      pc(1, 12'h100, 8'h00, 3'b100);
      @(posedge clk_i);
      special_mode_n_i <= 1'b0;
      wr(CFG_OFS, 32'hfc);
      chk({debug_lockout_disable_o, shadow_disable_o}, 2'b11);
      ar(SHW_HI_ADDR, -1);
      wr(CFG_OFS, 32'h3c);
      wr(DIV_OFS, 0);
      pc(0, 12'h100, 8'h00, 3'b001);
      wr(DIV_OFS, 32'h2aa);
      wr(PROT_OFS, 0);
      pc(0, SHW_HI_ADDR, 8'hfe, 3'b010);
      hi &= 8'hfe;
      pc(0, SHW_LO_ADDR, 8'h0f, 3'b010);
      lo &= 8'h0f;
      ar(SHW_LO_ADDR, lo);
      wr(PROT_OFS, 32'h80);
      pc(1, SHW_LO_ADDR, 8'h00, 3'b001);
      rst();
    end
  end

  // ==========================================
  // Watchdog
  initial
  begin
    #1_000_000;
    errors++;
    give_verdict();
  end
endmodule // nsl_config_loader_tb
